// >>> src/ish_pkg.sv
/*
 Shared constants and carriers for the interprocessor shared memory block.
 Assumes both subsystem ports run on one clock and one synchronous reset.
*/
package ish_pkg;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned ADDR_W     = 6;
	localparam int unsigned N_SHARED   = 8;
	localparam int unsigned N_RAM      = 10;
	localparam int unsigned N_CHAN     = 32;
	localparam int unsigned N_CHAN_INT = 4;
	localparam int unsigned RSP_LAT    = 2;

	// Region codes carried in the request
	localparam logic [3:0] RGN_M2C   = 4'h0;
	localparam logic [3:0] RGN_C2M   = 4'h1;
	localparam logic [3:0] RGN_SH0   = 4'h2;
	localparam logic [3:0] RGN_RAM_N = 4'hA;
	localparam logic [3:0] RGN_HS    = 4'hA;

	// Word offsets inside the handshake region
	localparam logic [ADDR_W-1:0] HS_SET = 6'h00;
	localparam logic [ADDR_W-1:0] HS_CLR = 6'h01;
	localparam logic [ADDR_W-1:0] HS_OUT = 6'h02;
	localparam logic [ADDR_W-1:0] HS_IN  = 6'h03;

	localparam logic [N_CHAN-1:0]     FLAGS_RST = 32'h0000_0000;
	localparam logic [N_CHAN_INT-1:0] INT_RST   = 4'h0;

	typedef enum logic {
		ISH_SRC_CPU = 1'b0,
		ISH_SRC_DMA = 1'b1
	} ish_src_type;

	typedef struct packed {
		logic              valid;
		logic              write;
		ish_src_type       src;
		logic [3:0]        region;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ish_req_type;

	typedef struct packed {
		logic              valid;
		logic              denied;
		logic              parity_err;
		ish_src_type       src;
		logic [DATA_W-1:0] rdata;
	} ish_rsp_type;

	localparam ish_rsp_type RSP_RST = '{valid: 1'b0, denied: 1'b0, parity_err: 1'b0,
		src: ISH_SRC_CPU, rdata: 32'h0000_0000};
endpackage

// >>> src/ish_ram_bank.sv
/*
 One parity-protected RAM bank: a single writer and two synchronous readers.
 Assumes the caller has already decided which side may write.
*/
`timescale 1ns/1ns
module ish_ram_bank
	import ish_pkg::*;
#(
	parameter int unsigned DEPTH = 64
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [ADDR_W-1:0] raddr_a,
	input  wire logic [ADDR_W-1:0] raddr_b,
	output logic      [DATA_W-1:0] rdata_a,
	output logic                   perr_a,
	output logic      [DATA_W-1:0] rdata_b,
	output logic                   perr_b
);
	// Top bit holds even parity over the data word
	logic [DATA_W:0] mem [DEPTH];
	logic [DATA_W:0] word_a_q;
	logic [DATA_W:0] word_b_q;

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= {^wdata, wdata};
		end
	end

	// Read before write on a colliding address
	always_ff @(posedge clk) begin
		if (rst) begin
			word_a_q <= '0;
			word_b_q <= '0;
		end else begin
			word_a_q <= mem[raddr_a];
			word_b_q <= mem[raddr_b];
		end
	end

	assign rdata_a = word_a_q[DATA_W-1:0];
	assign rdata_b = word_b_q[DATA_W-1:0];
	assign perr_a  = ^word_a_q;
	assign perr_b  = ^word_b_q;
endmodule

// >>> src/ish_shared_top.sv
/*
 Shared resource logic between master and control subsystems: two message
 RAMs, eight direction-selectable shared RAMs and 32 handshake channels.
 Assumes each side merges its processor and DMA onto one request port.
*/
`timescale 1ns/1ns
// Notes on behaviour
// - Master-to-control RAM: master writes, control reads
// - Control-to-master RAM: control writes, master reads
// - Parity on all RAMs, control side reaches them
// - Eight shared RAM blocks beside message RAMs
// - Each shared block: one writer, both sides read
// - Shared block direction selected per block
// - Thirty-two polled handshake channels
// - Four channels interrupt the control side
// - Same four channels interrupt the master side
module ish_shared_top
	import ish_pkg::*;
(
	input  wire logic                  CLK,
	input  wire logic                  RST,
	input  wire ish_req_type           M_REQ,
	input  wire ish_req_type           C_REQ,
	input  wire logic [N_SHARED-1:0]   SHARED_DIR,
	output ish_rsp_type                M_RSP,
	output ish_rsp_type                C_RSP,
	output logic      [N_CHAN_INT-1:0] M_INT,
	output logic      [N_CHAN_INT-1:0] C_INT
);
	logic [15:0]       owner_c;
	logic              m_ram_hit;
	logic              c_ram_hit;
	logic              m_hs_hit;
	logic              c_hs_hit;
	logic              m_wr_ok;
	logic              c_wr_ok;
	logic              m_deny;
	logic              c_deny;
	logic [N_CHAN-1:0] m_set;
	logic [N_CHAN-1:0] m_clr;
	logic [N_CHAN-1:0] c_set;
	logic [N_CHAN-1:0] c_clr;
	logic [N_CHAN-1:0] m2c_q;
	logic [N_CHAN-1:0] c2m_q;
	logic [DATA_W-1:0] m_hs_rd;
	logic [DATA_W-1:0] c_hs_rd;
	logic [DATA_W-1:0] m_rd [N_RAM];
	logic [DATA_W-1:0] c_rd [N_RAM];
	logic              m_pe [N_RAM];
	logic              c_pe [N_RAM];

	// First response stage
	logic              m_s1_valid_q;
	logic              m_s1_deny_q;
	logic              m_s1_ram_q;
	logic              m_s1_write_q;
	ish_src_type       m_s1_src_q;
	logic [3:0]        m_s1_rgn_q;
	logic [DATA_W-1:0] m_s1_hs_q;
	logic              c_s1_valid_q;
	logic              c_s1_deny_q;
	logic              c_s1_ram_q;
	logic              c_s1_write_q;
	ish_src_type       c_s1_src_q;
	logic [3:0]        c_s1_rgn_q;
	logic [DATA_W-1:0] c_s1_hs_q;

	// Region 0 master owned, region 1 control owned, shared by direction bit
	assign owner_c = {6'h00, SHARED_DIR, 1'b1, 1'b0};

	always_comb begin
		m_ram_hit = M_REQ.valid && (M_REQ.region < RGN_RAM_N);
		c_ram_hit = C_REQ.valid && (C_REQ.region < RGN_RAM_N);
		m_hs_hit  = M_REQ.valid && (M_REQ.region == RGN_HS);
		c_hs_hit  = C_REQ.valid && (C_REQ.region == RGN_HS);
		m_wr_ok   = m_ram_hit && M_REQ.write && !owner_c[M_REQ.region];
		c_wr_ok   = c_ram_hit && C_REQ.write && owner_c[C_REQ.region];
		// Denied requests answer but change nothing
		m_deny = (m_ram_hit && M_REQ.write && owner_c[M_REQ.region])
			|| (M_REQ.valid && !m_ram_hit && !m_hs_hit)
			|| (m_hs_hit && M_REQ.write && M_REQ.addr != HS_SET && M_REQ.addr != HS_CLR)
			|| (m_hs_hit && !M_REQ.write && M_REQ.addr != HS_OUT && M_REQ.addr != HS_IN);
		c_deny = (c_ram_hit && C_REQ.write && !owner_c[C_REQ.region])
			|| (C_REQ.valid && !c_ram_hit && !c_hs_hit)
			|| (c_hs_hit && C_REQ.write && C_REQ.addr != HS_SET && C_REQ.addr != HS_CLR)
			|| (c_hs_hit && !C_REQ.write && C_REQ.addr != HS_OUT && C_REQ.addr != HS_IN);
	end

	genvar r;
	generate
		for (r = 0; r < N_RAM; r++) begin : g_bank
			logic              bank_we;
			logic [ADDR_W-1:0] bank_wa;
			logic [DATA_W-1:0] bank_wd;
			// Only the owning side can ever reach the write port
			assign bank_we = owner_c[r] ? (c_wr_ok && C_REQ.region == 4'(r))
				: (m_wr_ok && M_REQ.region == 4'(r));
			assign bank_wa = owner_c[r] ? C_REQ.addr : M_REQ.addr;
			assign bank_wd = owner_c[r] ? C_REQ.wdata : M_REQ.wdata;
			ish_ram_bank #(
				.DEPTH(64)
			) u_bank (
				.clk    (CLK),
				.rst    (RST),
				.we     (bank_we),
				.waddr  (bank_wa),
				.wdata  (bank_wd),
				.raddr_a(M_REQ.addr),
				.raddr_b(C_REQ.addr),
				.rdata_a(m_rd[r]),
				.perr_a (m_pe[r]),
				.rdata_b(c_rd[r]),
				.perr_b (c_pe[r])
			);
		end
	endgenerate

	// Handshake writes and poll read selection
	always_comb begin
		m_set = (m_hs_hit && M_REQ.write && M_REQ.addr == HS_SET) ? M_REQ.wdata : '0;
		m_clr = (m_hs_hit && M_REQ.write && M_REQ.addr == HS_CLR) ? M_REQ.wdata : '0;
		c_set = (c_hs_hit && C_REQ.write && C_REQ.addr == HS_SET) ? C_REQ.wdata : '0;
		c_clr = (c_hs_hit && C_REQ.write && C_REQ.addr == HS_CLR) ? C_REQ.wdata : '0;
		m_hs_rd = (M_REQ.addr == HS_OUT) ? m2c_q : ((M_REQ.addr == HS_IN) ? c2m_q : '0);
		c_hs_rd = (C_REQ.addr == HS_OUT) ? c2m_q : ((C_REQ.addr == HS_IN) ? m2c_q : '0);
	end

	// Set wins over a clear in the same cycle so no signal is lost
	always_ff @(posedge CLK) begin
		if (RST) begin
			m2c_q <= FLAGS_RST;
			c2m_q <= FLAGS_RST;
		end else begin
			m2c_q <= (m2c_q & ~c_clr) | m_set;
			c2m_q <= (c2m_q & ~m_clr) | c_set;
		end
	end

	// Interrupts follow the flag level; polling still sees the same flag
	always_ff @(posedge CLK) begin
		if (RST) begin
			C_INT <= INT_RST;
			M_INT <= INT_RST;
		end else begin
			C_INT <= m2c_q[N_CHAN_INT-1:0];
			M_INT <= c2m_q[N_CHAN_INT-1:0];
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			m_s1_valid_q <= 1'b0;
			m_s1_deny_q  <= 1'b0;
			m_s1_ram_q   <= 1'b0;
			m_s1_write_q <= 1'b0;
			m_s1_src_q   <= ISH_SRC_CPU;
			m_s1_rgn_q   <= 4'h0;
			m_s1_hs_q    <= '0;
			c_s1_valid_q <= 1'b0;
			c_s1_deny_q  <= 1'b0;
			c_s1_ram_q   <= 1'b0;
			c_s1_write_q <= 1'b0;
			c_s1_src_q   <= ISH_SRC_CPU;
			c_s1_rgn_q   <= 4'h0;
			c_s1_hs_q    <= '0;
		end else begin
			m_s1_valid_q <= M_REQ.valid;
			m_s1_deny_q  <= m_deny;
			m_s1_ram_q   <= m_ram_hit;
			m_s1_write_q <= M_REQ.write;
			m_s1_src_q   <= M_REQ.src;
			m_s1_rgn_q   <= M_REQ.region;
			m_s1_hs_q    <= (m_hs_hit && !M_REQ.write) ? m_hs_rd : '0;
			c_s1_valid_q <= C_REQ.valid;
			c_s1_deny_q  <= c_deny;
			c_s1_ram_q   <= c_ram_hit;
			c_s1_write_q <= C_REQ.write;
			c_s1_src_q   <= C_REQ.src;
			c_s1_rgn_q   <= C_REQ.region;
			c_s1_hs_q    <= (c_hs_hit && !C_REQ.write) ? c_hs_rd : '0;
		end
	end

	// Parity flag only for RAM reads; read data from the RAM bank or the handshake stage
	always_ff @(posedge CLK) begin
		if (RST) begin
			M_RSP <= RSP_RST;
			C_RSP <= RSP_RST;
		end else begin
			M_RSP.valid      <= m_s1_valid_q;
			M_RSP.denied     <= m_s1_deny_q;
			M_RSP.src        <= m_s1_src_q;
			M_RSP.parity_err <= m_s1_ram_q && !m_s1_write_q && m_pe[m_s1_rgn_q];
			M_RSP.rdata      <= (m_s1_ram_q && !m_s1_write_q) ? m_rd[m_s1_rgn_q] : m_s1_hs_q;
			C_RSP.valid      <= c_s1_valid_q;
			C_RSP.denied     <= c_s1_deny_q;
			C_RSP.src        <= c_s1_src_q;
			C_RSP.parity_err <= c_s1_ram_q && !c_s1_write_q && c_pe[c_s1_rgn_q];
			C_RSP.rdata      <= (c_s1_ram_q && !c_s1_write_q) ? c_rd[c_s1_rgn_q] : c_s1_hs_q;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	property p_m2c_master_wr;
		M_REQ.valid && M_REQ.write && M_REQ.region == RGN_M2C |-> ##2 M_RSP.valid && !M_RSP.denied;
	endproperty
	a_m2c_master_wr: assert property (p_m2c_master_wr) else $error("master write refused");

	property p_m2c_ctl_wr;
		C_REQ.valid && C_REQ.write && C_REQ.region == RGN_M2C |-> ##2 C_RSP.valid && C_RSP.denied;
	endproperty
	a_m2c_ctl_wr: assert property (p_m2c_ctl_wr) else $error("control write not blocked");

	property p_c2m_master_wr;
		M_REQ.valid && M_REQ.write && M_REQ.region == RGN_C2M |-> ##2 M_RSP.valid && M_RSP.denied;
	endproperty
	a_c2m_master_wr: assert property (p_c2m_master_wr) else $error("master write passed");

	property p_ctl_ram_read;
		C_REQ.valid && !C_REQ.write && C_REQ.region < RGN_RAM_N
			|-> ##2 C_RSP.valid && !C_RSP.denied;
	endproperty
	a_ctl_ram_read: assert property (p_ctl_ram_read) else $error("control read refused");

	property p_shared_dir;
		M_REQ.valid && M_REQ.write && M_REQ.region >= RGN_SH0 && M_REQ.region < RGN_RAM_N
			|-> ##2 M_RSP.denied == $past(owner_c[M_REQ.region], 2);
	endproperty
	a_shared_dir: assert property (p_shared_dir) else $error("shared direction wrong");

	property p_set_wins;
		(m_set != '0) |=> ((m2c_q & $past(m_set)) == $past(m_set));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("handshake set lost");

	property p_ctl_int;
		m_set[0] && !c_clr[0] ##1 !c_clr[0] |-> ##1 C_INT[0];
	endproperty
	a_ctl_int: assert property (p_ctl_int) else $error("control interrupt missing");

	property p_mst_int;
		c_set[3] && !m_clr[3] ##1 !m_clr[3] |-> ##1 M_INT[3];
	endproperty
	a_mst_int: assert property (p_mst_int) else $error("master interrupt missing");

	property p_hs_poll;
		C_REQ.valid && !C_REQ.write && C_REQ.region == RGN_HS && C_REQ.addr == HS_IN
			|-> ##2 C_RSP.rdata == $past(m2c_q, 2);
	endproperty
	a_hs_poll: assert property (p_hs_poll) else $error("poll data wrong");

	c_msg_pass: cover property (M_REQ.valid && M_REQ.write && M_REQ.region == RGN_M2C
		##[1:4] C_REQ.valid && !C_REQ.write && C_REQ.region == RGN_M2C);
	c_int_ctl: cover property (m_set[0] ##2 C_INT[0]);
	c_dir_flip: cover property ($changed(SHARED_DIR));
	c_perr: cover property (C_RSP.parity_err);
endmodule

// >>> testbench/ish_proc_model.sv
/*
 Processor model for one side of the shared memory block: issues one
 request at a time, each held for a full clock cycle.
 Assumes the bench calls issue from one process only.
*/
`timescale 1ns/1ns
module ish_proc_model
	import ish_pkg::*;
(
	input  wire logic  clk,
	output ish_req_type req
);
	initial req = '0;

	// Polling and flag writes go through here too
	task automatic issue(input logic wr, input ish_src_type s, input logic [3:0] rgn,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge clk);
		req = '{valid: 1'b1, write: wr, src: s,
			region: rgn, addr: a, wdata: d};
		@(negedge clk);
		req.valid = 1'b0;
		// Released bus shows no stale data
		req.wdata = ~d;
		req.addr  = ~a;
	endtask
endmodule

// >>> testbench/interprocessor_shared_memory_ipc_test.sv
/*
 Self-checking bench for the shared memory block: both sides as models,
 answers scored against per-side queues of expected results.
 Assumes the two-cycle answer latency of the design.
*/
`timescale 1ns/1ns
module interprocessor_shared_memory_ipc_test;
	import ish_pkg::*;

	logic                  clk;
	logic                  rst;
	logic [N_SHARED-1:0]   sdir;
	ish_req_type           m_req;
	ish_req_type           c_req;
	ish_rsp_type           m_rsp;
	ish_rsp_type           c_rsp;
	logic [N_CHAN_INT-1:0] m_int;
	logic [N_CHAN_INT-1:0] c_int;
	int                    miscompares = 0;
	int                    comparisons = 0;
	logic [34:0]           mq[$];
	logic [34:0]           cq[$];
	logic [DATA_W-1:0]     d;
	logic [ADDR_W-1:0]     a;
	logic                  own;

	ish_shared_top i_dut (.CLK(clk), .RST(rst), .M_REQ(m_req), .C_REQ(c_req),
		.SHARED_DIR(sdir), .M_RSP(m_rsp), .C_RSP(c_rsp), .M_INT(m_int), .C_INT(c_int));
	ish_proc_model i_m (.clk(clk), .req(m_req));
	ish_proc_model i_c (.clk(clk), .req(c_req));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic results;
		$display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [34:0] e, input logic [34:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Expected: source echo, denied, parity error, read data
	task automatic send(input logic ctl, input logic wr, input logic [3:0] rgn,
		input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dd,
		input logic den, input logic [DATA_W-1:0] ed);
		ish_src_type sv;
		sv = ish_src_type'($urandom_range(1));
		if (ctl) begin
			cq.push_back({sv, den, 1'b0, ed});
			i_c.issue(wr, sv, rgn, ad, dd);
		end else begin
			mq.push_back({sv, den, 1'b0, ed});
			i_m.issue(wr, sv, rgn, ad, dd);
		end
	endtask

	// Answers stand one cycle, so look once per falling edge
	always @(negedge clk) begin
		if (m_rsp.valid === 1'b1) begin
			chk("m_rsp", mq.size() ? mq.pop_front() : 35'hx,
				{m_rsp.src, m_rsp.denied, m_rsp.parity_err, m_rsp.rdata});
		end
		if (c_rsp.valid === 1'b1) begin
			chk("c_rsp", cq.size() ? cq.pop_front() : 35'hx,
				{c_rsp.src, c_rsp.denied, c_rsp.parity_err, c_rsp.rdata});
		end
	end

	task automatic drain;
		for (int i = 0; i < 20 && (mq.size() || cq.size()); i++) @(negedge clk);
		if (mq.size() || cq.size()) begin
			miscompares++;
			$display("[FAIL] answers expected all seen missing");
			results();
		end
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("[FAIL] run expected finish seen timeout");
		results();
	end

	initial begin
		rst  = 1'b1;
		sdir = '0;
		void'($urandom(74321));
		repeat (3) @(negedge clk);
		rst = 1'b0;
		for (int r = 0; r < 2; r++) begin
			d = $urandom;
			a = 6'($urandom);
			send(r[0], 1'b1, r[3:0], a, d, 1'b0, '0);
			send(!r[0], 1'b1, r[3:0], a, ~d, 1'b1, '0);
			send(!r[0], 1'b0, r[3:0], a, '0, 1'b0, d);
			send(r[0], 1'b0, r[3:0], a, '0, 1'b0, d);
		end
		drain();
		$display("Test message RAMs done");
		for (int k = 0; k < 2; k++) begin
			@(negedge clk);
			sdir = k ? ~sdir : N_SHARED'($urandom);
			for (int b = 0; b < 8; b++) begin
				own = sdir[b];
				d   = $urandom;
				a   = 6'($urandom);
				send(own, 1'b1, 4'(b + 2), a, d, 1'b0, '0);
				send(!own, 1'b1, 4'(b + 2), a, ~d, 1'b1, '0);
				send(!own, 1'b0, 4'(b + 2), a, '0, 1'b0, d);
			end
			drain();
		end
		$display("Test shared blocks done");
		for (int s = 0; s < 2; s++) begin
			// Channels 0 and 3 always raised so both interrupt paths are exercised
			d = $urandom | 32'h0000_0009;
			send(s[0], 1'b0, RGN_HS, HS_OUT, '0, 1'b0, '0);
			send(s[0], 1'b1, RGN_HS, HS_SET, d, 1'b0, '0);
			repeat (2) @(negedge clk);
			chk("int", 35'(d[3:0]), 35'(s ? m_int : c_int));
			send(!s[0], 1'b0, RGN_HS, HS_IN, '0, 1'b0, d);
			send(s[0], 1'b0, RGN_HS, HS_OUT, '0, 1'b0, d);
			send(s[0], 1'b1, RGN_HS, HS_OUT, d, 1'b1, '0);
			send(s[0], 1'b0, RGN_HS, HS_SET, '0, 1'b1, '0);
			send(!s[0], 1'b1, RGN_HS, HS_CLR, d, 1'b0, '0);
			repeat (2) @(negedge clk);
			chk("int clear", 35'h0_0000_0000, 35'(s ? m_int : c_int));
			send(!s[0], 1'b0, RGN_HS, HS_IN, '0, 1'b0, '0);
		end
		drain();
		$display("Test handshake done");
		for (int g = 11; g < 16; g++) begin
			send(g[0], g[1], 4'(g), 6'($urandom), $urandom, 1'b1, '0);
		end
		drain();
		$display("Test unmapped done");
		results();
	end
endmodule
